// File: standby_clock_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module standby_clock_prescaler (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic HALT_INSTRUCTION,
  input wire logic RESTART_PIN,
  input wire logic RESTART_PORT_IS_INPUT,
  input wire logic EXT_CLOCK_MODE,
  input wire logic OSC_INPUT,
  input wire logic EXT_IRQ_PIN,
  input wire logic EXT_IRQ_ACK,
  input wire logic PRESCALER_STOP_BIT,
  output logic OSC_RUNNING,
  output logic STANDBY,
  output logic SYS_CLK_EN,
  output logic MCYC_EN,
  output logic WAKE_RESUME,
  output logic EXT_IRQ_REQ,
  output logic [11:0] PRESC_TAP
);
  standby_pkg::pwr_state_t state_r;
  standby_pkg::pwr_state_t state_nxt;
  logic [3:0] warm_r;
  logic [3:0] warm_nxt;
  logic [4:0] osc_div_r;
  logic [4:0] osc_div_nxt;
  logic [2:0] mcyc_r;
  logic [2:0] mcyc_nxt;
  logic osc_in_q_r;
  logic restart_q_r;
  logic irq_q_r;
  logic irq_pend_r;
  logic irq_pend_nxt;
  logic sys_en_r;
  logic sys_en_nxt;
  logic mcyc_en_r;
  logic mcyc_en_nxt;
  logic resume_r;
  logic resume_nxt;
  logic osc_tick;
  logic restart_edge;
  logic irq_edge;

  presc_if pif ();

  // Rising edge between a level and its previous sample
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Oscillator clock as an enable pulse
  always_comb
  begin
    osc_div_nxt = osc_div_r;
    osc_tick = 1'b0;
    // [R01] oscillator stops while in standby
    if (state_r == standby_pkg::ST_STANDBY)
    begin
      osc_div_nxt = 5'h00;
    end
    // External source: every rising edge is one oscillator clock
    else if (EXT_CLOCK_MODE)
    begin
      osc_tick = rise(OSC_INPUT, osc_in_q_r);
    end
    else if (osc_div_r == standby_pkg::OSC_DIV_LAST)
    begin
      osc_div_nxt = 5'h00;
      osc_tick = 1'b1;
    end
    else
    begin
      osc_div_nxt = osc_div_r + 5'h01;
    end
  end

  // Restart and interrupt edges; masked port cannot wake the device
  always_comb
  begin
    // [R10] restart only with the port set as input
    restart_edge = rise(RESTART_PIN, restart_q_r) & RESTART_PORT_IS_INPUT;
    irq_edge = rise(EXT_IRQ_PIN, irq_q_r);
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state sequencing
  always_comb
  begin
    state_nxt = state_r;
    warm_nxt = warm_r;
    resume_nxt = 1'b0;
    case (state_r)
      standby_pkg::ST_RUN:
      begin
        // [R01] enter standby after the halt cycle
        if (HALT_INSTRUCTION)
        begin
          state_nxt = standby_pkg::ST_STANDBY;
          // [R17] fresh count each entry
          warm_nxt = standby_pkg::WARM_ZERO;
        end
      end
      standby_pkg::ST_STANDBY:
      begin
        warm_nxt = standby_pkg::WARM_ZERO;
        // [R05] edge restarts the oscillator only
        if (restart_edge)
        begin
          state_nxt = standby_pkg::ST_WARMUP;
        end
      end
      standby_pkg::ST_WARMUP:
      begin
        // [R06] count eight stable clocks, then release
        if (osc_tick)
        begin
          if (warm_r == standby_pkg::WARM_LAST)
          begin
            state_nxt = standby_pkg::ST_RUN;
            // [R07] core continues from its held counter
            resume_nxt = 1'b1;
          end
          else
          begin
            warm_nxt = warm_r + 4'h1;
          end
        end
      end
      default:
      begin
        state_nxt = standby_pkg::ST_RUN;
        warm_nxt = standby_pkg::WARM_ZERO;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // System clock and machine cycle enables
  always_comb
  begin
    mcyc_nxt = mcyc_r;
    mcyc_en_nxt = 1'b0;
    // [R02] [R03] no system clock outside run, so core state holds
    sys_en_nxt = osc_tick & (state_r == standby_pkg::ST_RUN);
    // [R12] machine cycle is six oscillator clocks
    if (sys_en_nxt)
    begin
      if (mcyc_r == standby_pkg::MCYC_LAST)
      begin
        mcyc_nxt = 3'h0;
        mcyc_en_nxt = 1'b1;
      end
      else
      begin
        mcyc_nxt = mcyc_r + 3'h1;
      end
    end
  end

  // Interrupt latch; a new edge wins over the acknowledge
  always_comb
  begin
    irq_pend_nxt = irq_pend_r;
    if (EXT_IRQ_ACK)
    begin
      irq_pend_nxt = 1'b0;
    end
    // [R16] edge latched, even in standby
    if (irq_edge)
    begin
      irq_pend_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset returns to the initial condition
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    // [R04] reset clears all and leaves standby
    if (!RESET_N)
    begin
      state_r <= standby_pkg::ST_RUN;
      warm_r <= standby_pkg::WARM_ZERO;
      osc_div_r <= 5'h00;
      mcyc_r <= 3'h0;
      osc_in_q_r <= 1'b0;
      restart_q_r <= 1'b0;
      irq_q_r <= 1'b0;
      irq_pend_r <= 1'b0;
      sys_en_r <= 1'b0;
      mcyc_en_r <= 1'b0;
      resume_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      warm_r <= warm_nxt;
      osc_div_r <= osc_div_nxt;
      mcyc_r <= mcyc_nxt;
      osc_in_q_r <= OSC_INPUT;
      restart_q_r <= RESTART_PIN;
      irq_q_r <= EXT_IRQ_PIN;
      irq_pend_r <= irq_pend_nxt;
      sys_en_r <= sys_en_nxt;
      mcyc_en_r <= mcyc_en_nxt;
      resume_r <= resume_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler hookup
  assign pif.mcyc_en = mcyc_en_r;
  assign pif.stop = PRESCALER_STOP_BIT;

  prescaler u_presc (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .pif(pif.presc)
  );

  // Outputs
  assign OSC_RUNNING = (state_r != standby_pkg::ST_STANDBY);
  assign STANDBY = (state_r != standby_pkg::ST_RUN);
  assign SYS_CLK_EN = sys_en_r;
  assign MCYC_EN = mcyc_en_r;
  assign WAKE_RESUME = resume_r;
  // Request held back until the system clock runs again
  assign EXT_IRQ_REQ = irq_pend_r & (state_r == standby_pkg::ST_RUN);
  assign PRESC_TAP = pif.tap;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_halt;
    (state_r == standby_pkg::ST_RUN) && HALT_INSTRUCTION;
  endsequence
  sequence s_wake;
    (state_r == standby_pkg::ST_STANDBY) && restart_edge;
  endsequence

  property p_halt_enter;
    s_halt |=> (state_r == standby_pkg::ST_STANDBY) ##1 !SYS_CLK_EN;
  endproperty
  a_halt_enter: assert property (p_halt_enter) // [R01]
    else $error("halt did not enter standby");

  property p_gated;
    state_r != standby_pkg::ST_RUN |=> (!SYS_CLK_EN && !MCYC_EN)[*2];
  endproperty
  a_gated: assert property (p_gated) // [R02]
    else $error("system clock leaked outside run");

  property p_hold;
    state_r == standby_pkg::ST_STANDBY |=> $stable(mcyc_r);
  endproperty
  a_hold: assert property (p_hold) // [R03]
    else $error("held state changed in standby");

  property p_wake;
    s_wake |=> (state_r == standby_pkg::ST_WARMUP) && OSC_RUNNING
      && !SYS_CLK_EN;
  endproperty
  a_wake: assert property (p_wake) // [R05]
    else $error("restart edge not honoured");

  property p_masked;
    state_r == standby_pkg::ST_STANDBY && !RESTART_PORT_IS_INPUT
      |=> state_r == standby_pkg::ST_STANDBY;
  endproperty
  a_masked: assert property (p_masked) // [R10]
    else $error("masked port woke the device");

  property p_count;
    state_r == standby_pkg::ST_RUN && $past(state_r) ==
      standby_pkg::ST_WARMUP |-> $past(warm_r) == standby_pkg::WARM_LAST;
  endproperty
  a_count: assert property (p_count) // [R06]
    else $error("released before eight clocks");

  property p_resume;
    state_r == standby_pkg::ST_RUN && $past(state_r) ==
      standby_pkg::ST_WARMUP |-> WAKE_RESUME ##1 !WAKE_RESUME;
  endproperty
  a_resume: assert property (p_resume) // [R07]
    else $error("resume pulse wrong");

  property p_warm_clear;
    $rose(state_r == standby_pkg::ST_STANDBY) |-> warm_r ==
      standby_pkg::WARM_ZERO;
  endproperty
  a_warm_clear: assert property (p_warm_clear) // [R17]
    else $error("stabilisation count not cleared");

  // Only the standby state itself, the last warm-up edge may release
  property p_irq;
    irq_edge && (state_r == standby_pkg::ST_STANDBY)
      |=> irq_pend_r && !EXT_IRQ_REQ;
  endproperty
  a_irq: assert property (p_irq) // [R16]
    else $error("standby interrupt not latched or served early");

  property p_irq_set;
    irq_edge |=> irq_pend_r;
  endproperty
  a_irq_set: assert property (p_irq_set) // [R16]
    else $error("interrupt edge lost to acknowledge");
endmodule
`default_nettype wire

// File: standby_pkg.sv
// Overview of operation
// [R01] After the halt cycle the oscillator stops and operation ceases.
// [R02] With an external clock the device gates the system clock itself.
// [R03] Program counter, registers and memory hold unchanged during standby.
// [R04] Low reset initialises all, ends standby, restarts from initial state.
// [R05] Restart pin rising edge restarts oscillator; system clock stays gated.
// [R06] Eight stable oscillator clocks pass before the system clock runs.
// [R07] After restart-pin wake, execution resumes at the held program counter.
// [R08] External clock source must resume before standby is released.
// [R09] External clock source may stop during standby to save power.
// [R10] Restart-pin wake only works when restart port is masked as input.
// [R11] Power-on reset stays low until the internal oscillator is stable.
// [R12] Prescaler is a 12-bit counter on the six-clock machine cycle.
// [R13] Twelve prescaler ratios, 1/2 through 1/4096, feed timer and serial.
// [R14] Stop bit set halts the prescaler and suppresses its output clocks.
// [R15] Clearing the prescaler stop bit restarts counting from zero.
// [R16] External interrupt edge in standby is latched, served after release.
// [R17] Stabilisation counter clears on every standby entry.
`default_nettype none
package standby_pkg;
  // Fabric and oscillator rates
  localparam int REF_FREQ_KHZ = 125000;
  localparam int OSC_FREQ_KHZ = 4000;
  // Longest period rounds down, never below one cycle
  localparam int OSC_DIV_CYC = (REF_FREQ_KHZ / OSC_FREQ_KHZ) < 1 ? 1 :
    (REF_FREQ_KHZ / OSC_FREQ_KHZ);
  localparam logic [4:0] OSC_DIV_LAST = 5'(OSC_DIV_CYC - 1);
  // Oscillator clocks per machine cycle
  localparam logic [2:0] MCYC_LAST = 3'h5;
  // Stabilised oscillator clocks before the system clock runs
  localparam logic [3:0] WARM_LAST = 4'h7;
  localparam logic [3:0] WARM_ZERO = 4'h0;
  // Prescaler width and number of taps
  localparam int PRESC_W = 12;
  localparam logic [11:0] PRESC_ZERO = 12'h000;
  // Power states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_STANDBY = 3'h2,
    ST_WARMUP = 3'h4
  } pwr_state_t;
endpackage
`default_nettype wire

// File: presc_if.sv
`timescale 1ns/10ps
`default_nettype none
// Links the power controller to the prescaler
interface presc_if;
  logic mcyc_en;
  logic stop;
  logic [standby_pkg::PRESC_W-1:0] tap;
  modport ctrl (output mcyc_en, output stop, input tap);
  modport presc (input mcyc_en, input stop, output tap);
endinterface
`default_nettype wire

// File: prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module prescaler (
  input wire logic clk,
  input wire logic rst_n,
  presc_if.presc pif
);
  logic [standby_pkg::PRESC_W-1:0] cnt_r;
  logic [standby_pkg::PRESC_W-1:0] cnt_nxt;
  logic [standby_pkg::PRESC_W-1:0] tap_r;
  logic [standby_pkg::PRESC_W-1:0] tap_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Counter and tap pulses
  always_comb
  begin
    cnt_nxt = cnt_r;
    tap_nxt = standby_pkg::PRESC_ZERO;
    // [R14] [R15] stop holds at zero
    if (pif.stop)
    begin
      cnt_nxt = standby_pkg::PRESC_ZERO;
    end
    // [R12] [R13] count machine cycles, tap k divides by 2^(k+1)
    else if (pif.mcyc_en)
    begin
      cnt_nxt = cnt_r + 12'h001;
      for (int k = 0; k < standby_pkg::PRESC_W; k++)
      begin
        tap_nxt[k] = &(cnt_r | ~((12'h002 << k) - 12'h001));
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= standby_pkg::PRESC_ZERO;
      tap_r <= standby_pkg::PRESC_ZERO;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tap_r <= tap_nxt;
    end
  end

  assign pif.tap = tap_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_stop_quiet;
    pif.stop |=> (cnt_r == standby_pkg::PRESC_ZERO) && (tap_r == 12'h000);
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) // [R14]
    else $error("prescaler not quiet while stopped");

  property p_half_tap;
    !pif.stop && pif.mcyc_en && cnt_r[0] |=> tap_r[0];
  endproperty
  a_half_tap: assert property (p_half_tap) // [R13]
    else $error("divide-by-two tap missed");

  property p_restart_zero;
    $fell(pif.stop) |-> cnt_r == standby_pkg::PRESC_ZERO;
  endproperty
  a_restart_zero: assert property (p_restart_zero) // [R15]
    else $error("prescaler did not restart from zero");
endmodule
`default_nettype wire

// File: osc_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// External clock source feeding the oscillator input
module osc_source_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [3:0] half,
  output logic osc
);
  logic [3:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////
  // stops when idle
  // Held low while stopped, so the block sees no stray edges
  always_ff @(posedge clk)
  begin
    if (!run)
    begin
      cnt_r <= 4'h0;
      osc <= 1'b0;
    end
    else if (cnt_r >= half)
    begin
      cnt_r <= 4'h0;
      osc <= ~osc;
    end
    else
      cnt_r <= cnt_r + 4'h1;
  end
endmodule
`default_nettype wire

// File: standby_clock_prescaler_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module standby_clock_prescaler_tb_top;
  logic ref_clk, reset_n, halt, pin, port_in, ext_mode, irq, ack, stop;
  logic osc_run;
  logic [3:0] osc_half;
  logic osc_in, osc_running, standby, sys_clk_en, mcyc_en, wake, irq_req;
  logic [11:0] presc_tap;
  int err_total, checks;
  standby_clock_prescaler i_standby_clock_prescaler (
    .REF_CLK(ref_clk),
    .RESET_N(reset_n),
    .HALT_INSTRUCTION(halt),
    .RESTART_PIN(pin),
    .RESTART_PORT_IS_INPUT(port_in),
    .EXT_CLOCK_MODE(ext_mode),
    .OSC_INPUT(osc_in),
    .EXT_IRQ_PIN(irq),
    .EXT_IRQ_ACK(ack),
    .PRESCALER_STOP_BIT(stop),
    .OSC_RUNNING(osc_running),
    .STANDBY(standby),
    .SYS_CLK_EN(sys_clk_en),
    .MCYC_EN(mcyc_en),
    .WAKE_RESUME(wake),
    .EXT_IRQ_REQ(irq_req),
    .PRESC_TAP(presc_tap)
  );
  osc_source_model i_osc_source_model (
    .clk(ref_clk),
    .run(osc_run),
    .half(osc_half),
    .osc(osc_in)
  );
  ////////////////////////////////////////////////////////////////////////
  // Clock at 8 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Step to just after the next edges
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cycles from pin edge to resume, counting oscillator input rises
  task automatic wait_wake(output int n, output int rises);
    logic prev;
    n = 0;
    rises = 0;
    prev = osc_in;
    while (n < 2000 && wake !== 1'b1)
    begin
      cyc(1);
      n++;
      if (osc_in === 1'b1 && prev === 1'b0)
        rises++;
      prev = osc_in;
    end
  endtask
  // Gap between two pulses of the chosen strobe
  task automatic gap(input bit m, output int n);
    n = 1;
    while (n < 800 && (m ? mcyc_en : sys_clk_en) !== 1'b1)
    begin
      cyc(1);
      n++;
    end
    n = 1;
    cyc(1);
    while (n < 800 && (m ? mcyc_en : sys_clk_en) !== 1'b1)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic do_halt();
    halt = 1'b1;
    cyc(1);
    halt = 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_run();
    int n;
    check(16'(osc_running), 16'h0001, "running after reset");
    check(16'(standby), 16'h0000, "standby after reset");
    gap(1'b0, n);
    check(16'(n), 16'h001F, "osc tick spacing");
    gap(1'b1, n);
    check(16'(n), 16'h00BA, "machine cycle spacing");
    $display("test run ended");
  endtask
  task automatic t_halt();
    int n, p;
    do_halt();
    check(16'(standby), 16'h0001, "standby after halt");
    check(16'(osc_running), 16'h0000, "osc after halt");
    p = 0;
    for (n = 0; n < 200; n++)
    begin
      cyc(1);
      p += (sys_clk_en | mcyc_en | (|presc_tap)) === 1'b1;
    end
    check(16'(p), 16'h0000, "clocks gated in standby");
    $display("test halt ended");
  endtask
  task automatic t_wake_masked();
    port_in = 1'b0;
    pin = 1'b1;
    cyc(300);
    check(16'(standby), 16'h0001, "masked wake");
    check(16'(osc_running), 16'h0000, "masked osc");
    pin = 1'b0;
    cyc(2);
    $display("test masked wake ended");
  endtask
  task automatic t_wake_int();
    int n, r;
    irq = 1'b1;
    cyc(2);
    irq = 1'b0;
    check(16'(irq_req), 16'h0000, "irq held in standby");
    port_in = 1'b1;
    pin = 1'b1;
    cyc(2);
    check(16'(osc_running), 16'h0001, "osc restarts");
    check(16'(standby), 16'h0001, "still gated");
    wait_wake(n, r);
    check(16'(n >= 246 && n <= 254), 16'h0001, "warm-up length");
    check(16'(wake), 16'h0001, "resume pulse");
    check(16'(standby), 16'h0000, "released at resume");
    cyc(1);
    check(16'(wake), 16'h0000, "resume pulse one cycle");
    cyc(1);
    check(16'(irq_req), 16'h0001, "irq after release");
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(1);
    check(16'(irq_req), 16'h0000, "irq acknowledged");
    // Edge beside an acknowledge must stay pending
    irq = 1'b1;
    ack = 1'b1;
    cyc(1);
    {irq, ack} = 2'h0;
    cyc(1);
    check(16'(irq_req), 16'h0001, "edge wins over ack");
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(1);
    check(16'(irq_req), 16'h0000, "second ack");
    $display("test internal wake ended");
  endtask
  task automatic t_wake_ext();
    int n, r, p;
    ext_mode = 1'b1;
    osc_half = 4'h3;
    pin = 1'b0;
    cyc(40);
    do_halt();
    osc_run = 1'b0;
    cyc(50);
    osc_run = 1'b1;
    p = 0;
    // Running source must not reach the core in standby
    for (n = 0; n < 20; n++)
    begin
      cyc(1);
      p += (sys_clk_en | mcyc_en | wake) === 1'b1;
    end
    check(16'(p), 16'h0000, "ext clock gated");
    check(16'(standby), 16'h0001, "standby with source on");
    pin = 1'b1;
    wait_wake(n, r);
    check(16'(r), 16'h0008, "external ticks");
    $display("test external wake ended");
  endtask
  task automatic t_reset_mid();
    do_halt();
    reset_n = 1'b0;
    cyc(3);
    check(16'(standby), 16'h0000, "reset ends standby");
    check(16'(osc_running), 16'h0001, "reset runs osc");
    reset_n = 1'b1;
    cyc(2);
    $display("test reset ended");
  endtask
  task automatic t_presc();
    int k, mc, n;
    int first [12];
    logic [11:0] seen;
    osc_half = 4'h0;
    stop = 1'b1;
    seen = 12'h000;
    for (n = 0; n < 200; n++)
    begin
      cyc(1);
      seen = seen | presc_tap;
    end
    check(16'(seen), 16'h0000, "taps while stopped");
    stop = 1'b0;
    mc = (mcyc_en === 1'b1);
    seen = 12'h000;
    for (n = 0; n < 60000 && seen !== 12'hFFF; n++)
    begin
      cyc(1);
      mc += (mcyc_en === 1'b1);
      for (k = 0; k < 12; k++)
        if (presc_tap[k] === 1'b1 && !seen[k])
        begin
          seen[k] = 1'b1;
          first[k] = mc;
        end
    end
    for (k = 0; k < 12; k++)
      check(16'(first[k]), 16'(2 << k), "first tap");
    $display("test prescaler ended");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard, well past the longest expected run
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
  // Main sequence; reset covers the oscillator settling time
  initial
  begin
    {halt, pin, port_in, ext_mode, irq, ack, stop, osc_run} = 8'h00;
    osc_half = 4'h0;
    err_total = 0;
    checks = 0;
    reset_n = 1'b0;
    cyc(16);
    reset_n = 1'b1;
    cyc(1);
    t_run();
    t_halt();
    t_wake_masked();
    t_wake_int();
    t_wake_ext();
    t_reset_mid();
    t_presc();
    print_verdict();
  end
endmodule
`default_nettype wire
